// ---- core/key_level_detect.sv ----
// Per-line comparison of synchronised levels against the selectors.
// Assumes sync_level is already in the clk_sys domain.
`timescale 1ns/1ps
module key_level_detect #(
  parameter int unsigned W = 8
) (
  key_line_if.detect lines
);

  // ==========================================================
  // One comparator per keypad line
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_line
      // Selector 0 looks for low, selector 1 looks for high
      assign lines.hit[g] = lines.level_sel[g] ? lines.sync_level[g]
        : ~lines.sync_level[g];
    end
  endgenerate

endmodule // key_level_detect

// ---- core/key_line_if.sv ----
// Carrier between the keypad top and its line helpers.
// Assumes all three modules share clk_sys.
`timescale 1ns/1ps
interface key_line_if #(
  parameter int unsigned W = 8
);
  logic [W-1:0] sync_level;
  logic [W-1:0] level_sel;
  logic [W-1:0] hit;

  modport sync_src (output sync_level);
  modport detect (input sync_level, input level_sel, output hit);
  modport core (input sync_level, input hit, output level_sel);
endinterface

// ---- core/key_line_sync.sv ----
// Three-stage synchroniser bank for the keypad port lines.
// Assumes asynchronous pin inputs; drives the carrier's sync_level.
`timescale 1ns/1ps
module key_line_sync #(
  parameter int unsigned W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [W-1:0] key_pins,
  key_line_if.sync_src lines
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync2_q;
  logic [W-1:0] sync2_d;
  logic [W-1:0] sync3_q;
  logic [W-1:0] sync3_d;
  logic [W-1:0] stable_q;
  logic [W-1:0] stable_d;

  // ==========================================================
  // Next state
  always_comb
  begin
    meta_d = key_pins;
    sync2_d = meta_q;
    sync3_d = sync2_q;
    // A change counts only when the second and third stage agree
    stable_d = (sync2_q & ~(sync2_q ^ sync3_q))
      | (stable_q & (sync2_q ^ sync3_q));
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= keypad_pkg::SYNC_RESET[W-1:0];
      sync2_q <= keypad_pkg::SYNC_RESET[W-1:0];
      sync3_q <= keypad_pkg::SYNC_RESET[W-1:0];
      stable_q <= keypad_pkg::SYNC_RESET[W-1:0];
    end
    else
    begin
      meta_q <= meta_d;
      sync2_q <= sync2_d;
      sync3_q <= sync3_d;
      stable_q <= stable_d;
    end
  end

  assign lines.sync_level = stable_q;

  property p_stable_agree;
    @(posedge clk_sys) disable iff (!rst_b)
    (stable_q != $past(stable_q)) |-> ($past(sync2_q) == $past(sync3_q));
  endproperty
  a_stable_agree: assert property (p_stable_agree)
    else $error("Synchronised level moved without stage agreement");

endmodule // key_line_sync

// ---- core/keypad_level_interrupt.sv ----
// Eight-line keypad level interrupt unit with its three registers.
// Assumes a core-side register bus on clk_sys with one-cycle strobes
// and a global keypad enable bit held in the core's own enable reg.
//
// Overview of operation
// - A line's flag sets whenever its pin shows the selected level.
// - Interrupt request rises when any flagged line is also enabled.
// - Reading the flag register clears flags 0, 1 and 3 to 7.
// - Flag 2 survives reads; software must clear it by writing.
// - Reset loads zero into flags, enables and level selectors.
// - A disabled line is plain I/O and never requests an interrupt.
// - An enabled line lets its flag request an interrupt.
// - Selector bit clear detects a low level on that line.
// - Selector bit set detects a high level on that line.
// - Eight independent sources share one request toward the core.
// - Global keypad enable gates the combined request.
`timescale 1ns/1ps
module keypad_level_interrupt #(
  parameter int unsigned LINES = keypad_pkg::KEY_LINES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [LINES-1:0] key_pins,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic key_global_irq_enable,
  output logic [LINES-1:0] key_line_keypad_mode,
  output logic key_irq_request
);

  // ==========================================================
  // Address decode
  function automatic keypad_pkg::reg_sel_t decode(
    input logic [7:0] addr
  );
    keypad_pkg::reg_sel_t sel;
    sel = keypad_pkg::ACC_NONE;
    case (addr)
      keypad_pkg::ADDR_LEVEL_SELECT: sel = keypad_pkg::ACC_LEVEL_SELECT;
      keypad_pkg::ADDR_LINE_ENABLE: sel = keypad_pkg::ACC_LINE_ENABLE;
      keypad_pkg::ADDR_LINE_FLAGS: sel = keypad_pkg::ACC_LINE_FLAGS;
      default: sel = keypad_pkg::ACC_NONE;
    endcase
    return sel;
  endfunction

  keypad_pkg::reg_sel_t acc_sel;
  logic wr_level_sel;
  logic wr_enable;
  logic wr_flags;
  logic rd_flags;

  assign acc_sel = decode(sfr_addr);
  assign wr_level_sel = sfr_wr_en
    && (acc_sel == keypad_pkg::ACC_LEVEL_SELECT);
  assign wr_enable = sfr_wr_en
    && (acc_sel == keypad_pkg::ACC_LINE_ENABLE);
  assign wr_flags = sfr_wr_en
    && (acc_sel == keypad_pkg::ACC_LINE_FLAGS);
  assign rd_flags = sfr_rd_en
    && (acc_sel == keypad_pkg::ACC_LINE_FLAGS);

  // ==========================================================
  // Line synchronisation and level comparison
  key_line_if #(.W(LINES)) key_bus ();

  key_line_sync #(.W(LINES)) u_sync (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .key_pins (key_pins),
    .lines (key_bus)
  );

  key_level_detect #(.W(LINES)) u_detect (
    .lines (key_bus)
  );

  logic [LINES-1:0] line_hit;
  assign line_hit = key_bus.hit;

  // ==========================================================
  // Configuration registers
  logic [LINES-1:0] key_level_selectors_q;
  logic [LINES-1:0] key_level_selectors_d;
  logic [LINES-1:0] key_line_enables_q;
  logic [LINES-1:0] key_line_enables_d;

  always_comb
  begin
    key_level_selectors_d = key_level_selectors_q;
    key_line_enables_d = key_line_enables_q;
    if (wr_level_sel)
    begin
      key_level_selectors_d = sfr_wdata[LINES-1:0];
    end
    if (wr_enable)
    begin
      key_line_enables_d = sfr_wdata[LINES-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      key_level_selectors_q <= keypad_pkg::REG_RESET[LINES-1:0];
      key_line_enables_q <= keypad_pkg::REG_RESET[LINES-1:0];
    end
    else
    begin
      key_level_selectors_q <= key_level_selectors_d;
      key_line_enables_q <= key_line_enables_d;
    end
  end

  assign key_bus.level_sel = key_level_selectors_q;
  // Disabled lines stay ordinary port pins
  assign key_line_keypad_mode = key_line_enables_q;

  // ==========================================================
  // Line flags
  // Clears are applied first and hits last, so a level present in
  // the clearing cycle is never lost.
  logic [LINES-1:0] key_line_flags_q;
  logic [LINES-1:0] key_line_flags_d;

  always_comb
  begin
    key_line_flags_d = key_line_flags_q;
    if (rd_flags)
    begin
      key_line_flags_d = key_line_flags_d
        & ~keypad_pkg::READ_CLEAR_MASK[LINES-1:0];
    end
    if (wr_flags)
    begin
      // Writing 0 clears a flag, writing 1 leaves it alone
      key_line_flags_d = key_line_flags_d & sfr_wdata[LINES-1:0];
    end
    key_line_flags_d = key_line_flags_d | line_hit;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      key_line_flags_q <= keypad_pkg::REG_RESET[LINES-1:0];
    end
    else
    begin
      key_line_flags_q <= key_line_flags_d;
    end
  end

  // ==========================================================
  // Read data
  // Registered so the value returned is the one seen before the
  // read-clear takes effect.
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = rdata_q;
    if (sfr_rd_en)
    begin
      case (acc_sel)
        keypad_pkg::ACC_LEVEL_SELECT:
          rdata_d = 8'(key_level_selectors_q);
        keypad_pkg::ACC_LINE_ENABLE:
          rdata_d = 8'(key_line_enables_q);
        keypad_pkg::ACC_LINE_FLAGS:
          rdata_d = 8'(key_line_flags_q);
        default:
          rdata_d = keypad_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= keypad_pkg::READ_DATA_RESET;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;

  // ==========================================================
  // Interrupt request
  // All lines fold into one request toward the core.
  logic irq_q;
  logic irq_d;

  always_comb
  begin
    irq_d = key_global_irq_enable
      && (|(key_line_flags_q & key_line_enables_q));
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  assign key_irq_request = irq_q;

  // ==========================================================
  // Assertions
  property p_flag_sets;
    @(posedge clk_sys) disable iff (!rst_b)
    (line_hit != '0) |=>
      ((key_line_flags_q & $past(line_hit)) == $past(line_hit));
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("Line hit did not set its flag");

  property p_irq_follows;
    @(posedge clk_sys) disable iff (!rst_b)
    (key_global_irq_enable
      && ((key_line_flags_q & key_line_enables_q) != '0))
      |=> key_irq_request;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("Enabled flag did not raise the request");

  property p_read_clear;
    @(posedge clk_sys) disable iff (!rst_b)
    (rd_flags && !sfr_wr_en && (line_hit == '0)) |=>
      ((key_line_flags_q & keypad_pkg::READ_CLEAR_MASK[LINES-1:0]) == '0);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Flag read did not clear the read-clear flags");

  property p_read_data;
    @(posedge clk_sys) disable iff (!rst_b)
    rd_flags |=> (sfr_rdata == 8'($past(key_line_flags_q)));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("Flag read returned a value other than the flags");

  // A flag write just after the read may clear flag 2 legally
  localparam int unsigned SW_LINE = keypad_pkg::SW_ONLY_LINE;
  property p_keep_line2;
    @(posedge clk_sys) disable iff (!rst_b)
    (rd_flags && !sfr_wr_en && key_line_flags_q[SW_LINE]) ##1 !wr_flags
      |-> key_line_flags_q[SW_LINE] [*2];
  endproperty
  a_keep_line2: assert property (p_keep_line2)
    else $error("Flag 2 was cleared by a read");

  property p_sw_clear_line2;
    @(posedge clk_sys) disable iff (!rst_b)
    (wr_flags && !sfr_wdata[SW_LINE] && !line_hit[SW_LINE])
      |=> !key_line_flags_q[SW_LINE];
  endproperty
  a_sw_clear_line2: assert property (p_sw_clear_line2)
    else $error("Software write did not clear flag 2");

  property p_reset_zero;
    @(posedge clk_sys)
    !rst_b |-> ((key_line_flags_q == '0) && (key_line_enables_q == '0)
      && (key_level_selectors_q == '0) && !key_irq_request);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("Registers not zero during reset");

  property p_disabled_quiet;
    @(posedge clk_sys) disable iff (!rst_b)
    (key_line_enables_q == '0) |=> !key_irq_request;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("Request raised with every line disabled");

  property p_low_detect;
    @(posedge clk_sys) disable iff (!rst_b)
    ((~key_level_selectors_q & ~key_bus.sync_level) != '0) |=>
      ((key_line_flags_q
        & $past(~key_level_selectors_q & ~key_bus.sync_level))
        == $past(~key_level_selectors_q & ~key_bus.sync_level));
  endproperty
  a_low_detect: assert property (p_low_detect)
    else $error("Low level on a low-select line did not flag");

  property p_high_detect;
    @(posedge clk_sys) disable iff (!rst_b)
    ((key_level_selectors_q & key_bus.sync_level) != '0) |=>
      ((key_line_flags_q
        & $past(key_level_selectors_q & key_bus.sync_level))
        == $past(key_level_selectors_q & key_bus.sync_level));
  endproperty
  a_high_detect: assert property (p_high_detect)
    else $error("High level on a high-select line did not flag");

  property p_global_gate;
    @(posedge clk_sys) disable iff (!rst_b)
    !key_global_irq_enable |=> !key_irq_request;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("Request raised with the global enable clear");

  property p_irq_cause;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(key_irq_request) |->
      ($past(key_line_flags_q & key_line_enables_q) != '0);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("Request rose without an enabled flag");

  property p_reset_again;
    @(posedge clk_sys) disable iff (!rst_b)
    (rd_flags && (line_hit != '0)) |=>
      ((key_line_flags_q & $past(line_hit)) == $past(line_hit));
  endproperty
  a_reset_again: assert property (p_reset_again)
    else $error("Persisting level lost in the clearing cycle");

endmodule // keypad_level_interrupt

// ---- core/keypad_pkg.sv ----
// Shared constants of the keypad level interrupt block.
// Assumes an 8-bit special function register bus from the core.
package keypad_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned KEY_LINES = 8;
  localparam int unsigned REG_W = 8;

  // ==========================================================
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_LEVEL_SELECT = 8'h9C;
  localparam logic [7:0] ADDR_LINE_ENABLE = 8'h9D;
  localparam logic [7:0] ADDR_LINE_FLAGS = 8'h9E;

  // ==========================================================
  // Reset values and masks
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Flags that a read clears; line 2 is left for software
  localparam logic [7:0] READ_CLEAR_MASK = 8'hFB;
  localparam int unsigned SW_ONLY_LINE = 2;
  // Keypad lines idle high behind pull-ups
  localparam logic [7:0] SYNC_RESET = 8'hFF;

  // ==========================================================
  // Register access decode
  typedef enum {
    ACC_NONE,
    ACC_LEVEL_SELECT,
    ACC_LINE_ENABLE,
    ACC_LINE_FLAGS
  } reg_sel_t;

endpackage

// ---- tb/keypad_switches.sv ----
// Behavioural keypad switch matrix on the eight port lines.
// Assumes pull-ups on every line, so a released key reads high.
`timescale 1ns/1ps
module keypad_switches (
  input wire logic [7:0] press,
  output logic [7:0] key_pins
);
  // ==========================================================
  // Switches
  // A closed key pulls its line low; the pull-up holds it high
  // otherwise, so a released line never floats.
  assign key_pins = ~press;
endmodule // keypad_switches

// ---- tb/testbench.sv ----
// Self-checking bench for the keypad level interrupt unit.
// Assumes the register bus contract: one-cycle strobes, registered read.
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // Signals
  logic clk_sys = 1'b0;
  logic rst_b;
  logic [7:0] press;
  logic [7:0] key_pins;
  logic [7:0] sfr_addr;
  logic sfr_wr_en;
  logic sfr_rd_en;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic glob;
  logic [7:0] mode;
  logic irq;
  int err_count;
  int checks;
  int cycles;

  // ==========================================================
  // Instances
  keypad_switches keypad_switches_i (
    .press(press),
    .key_pins(key_pins)
  );

  keypad_level_interrupt keypad_level_interrupt_i (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .key_pins(key_pins),
    .sfr_addr(sfr_addr),
    .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .key_global_irq_enable(glob),
    .key_line_keypad_mode(mode),
    .key_irq_request(irq)
  );

  // ==========================================================
  // Clock and watchdog
  always #2 clk_sys = ~clk_sys;

  // Whole run needs some 180 cycles; the ceiling leaves ample slack
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr_en = 1'b1;
    @(negedge clk_sys);
    sfr_wr_en = 1'b0;
  endtask

  // Sampled a full cycle after the strobe; read data holds until
  // the next strobe, so the extra cycle costs nothing.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    @(negedge clk_sys);
    sfr_rd_en = 1'b0;
    @(negedge clk_sys);
    chk(sfr_rdata, exp);
  endtask

  task automatic finish_test();
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    rst_b = 1'b0;
    press = 8'h00;
    sfr_addr = 8'h00;
    sfr_wr_en = 1'b0;
    sfr_rd_en = 1'b0;
    sfr_wdata = 8'h00;
    glob = 1'b1;
    err_count = 0;
    checks = 0;
    cycles = 0;
    idle(10);
    rst_b = 1'b1;
    chk(mode, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rd(keypad_pkg::ADDR_LEVEL_SELECT, 8'h00);
    rd(keypad_pkg::ADDR_LINE_ENABLE, 8'h00);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    // Unmapped place: write ignored, read gives zero
    wr(8'h9F, 8'hFF);
    rd(8'h9F, 8'h00);
    wr(keypad_pkg::ADDR_LINE_ENABLE, 8'hA5);
    rd(keypad_pkg::ADDR_LINE_ENABLE, 8'hA5);
    chk(mode, 8'hA5);
    // Line 3 selects high while its pin idles high; line not enabled
    wr(keypad_pkg::ADDR_LEVEL_SELECT, 8'h08);
    rd(keypad_pkg::ADDR_LEVEL_SELECT, 8'h08);
    idle(8);
    chk({7'h00, irq}, 8'h00);
    wr(keypad_pkg::ADDR_LEVEL_SELECT, 8'h00);
    idle(8);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h08);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    // Line 5 enabled, low level selected
    press = 8'h20;
    idle(8);
    chk({7'h00, irq}, 8'h01);
    glob = 1'b0;
    idle(2);
    chk({7'h00, irq}, 8'h00);
    glob = 1'b1;
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h20);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h20);
    press = 8'h00;
    idle(8);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h20);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    // Line 2 keeps its flag through reads until written to zero
    press = 8'h04;
    idle(8);
    press = 8'h00;
    idle(8);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h04);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wr(keypad_pkg::ADDR_LINE_FLAGS, 8'hFB);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    idle(2);
    chk({7'h00, irq}, 8'h00);
    // All eight lines select high and act independently
    wr(keypad_pkg::ADDR_LEVEL_SELECT, 8'hFF);
    idle(8);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'hFF);
    wr(keypad_pkg::ADDR_LEVEL_SELECT, 8'h00);
    idle(8);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'hFF);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h04);
    wr(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    wr(keypad_pkg::ADDR_LINE_ENABLE, 8'h00);
    chk(mode, 8'h00);
    // Reset in mid-run with every register holding non-zero contents
    wr(keypad_pkg::ADDR_LEVEL_SELECT, 8'h5A);
    wr(keypad_pkg::ADDR_LINE_ENABLE, 8'hFF);
    idle(8);
    chk({7'h00, irq}, 8'h01);
    rst_b = 1'b0;
    idle(2);
    chk(mode, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rst_b = 1'b1;
    rd(keypad_pkg::ADDR_LEVEL_SELECT, 8'h00);
    rd(keypad_pkg::ADDR_LINE_ENABLE, 8'h00);
    rd(keypad_pkg::ADDR_LINE_FLAGS, 8'h00);
    finish_test();
  end
endmodule // testbench
